// ===== rtl/pcrm_consts.svh
// Purpose: command codes, reset values and timing counts of the command register bank
// Assumes: codes are the command byte of the serial transaction
// Notes:   definitions only
`ifndef PCRM_CONSTS_SVH
`define PCRM_CONSTS_SVH
`define PCRM_CMD_PAGE        8'h00
`define PCRM_CMD_OPMODE      8'h01
`define PCRM_CMD_ENSRC       8'h02
`define PCRM_CMD_FCLR        8'h03
`define PCRM_CMD_PGWR        8'h05
`define PCRM_CMD_PGRD        8'h06
`define PCRM_CMD_PROT        8'h10
`define PCRM_CMD_SAVE        8'h15
`define PCRM_CMD_RELOAD      8'h16
`define PCRM_CMD_FEAT        8'h19
`define PCRM_CMD_AMASK       8'h1B
`define PCRM_CMD_VFMT        8'h20
`define PCRM_CMD_VSET        8'h21
`define PCRM_CMD_VMAX        8'h24
`define PCRM_CMD_MHI         8'h25
`define PCRM_CMD_MLO         8'h26
`define PCRM_CMD_SLEW        8'h27
`define PCRM_CMD_FSW         8'h33
`define PCRM_CMD_VINON       8'h35
`define PCRM_CMD_VINOFF      8'h36
`define PCRM_CMD_IGAIN       8'h38
`define PCRM_CMD_OVF         8'h40
`define PCRM_CMD_OVR         8'h41
`define PCRM_CMD_OVW         8'h42
`define PCRM_CMD_UVW         8'h43
`define PCRM_RESV_LO         8'hD0
`define PCRM_RST_PAGE        8'h00
`define PCRM_RST_OPMODE      8'h40
`define PCRM_RST_ENSRC       8'h1E
`define PCRM_RST_PROT        8'h00
`define PCRM_VAL_FEAT        8'hB0
`define PCRM_RST_AMASK       8'h00
`define PCRM_VAL_VFMT        8'h16
`define PCRM_RST_VSET        16'h6000
`define PCRM_RST_VMAX        16'hF000
`define PCRM_RST_MHI         16'h64CD
`define PCRM_RST_MLO         16'h5B33
`define PCRM_RST_SLEW        16'hAA00
`define PCRM_RST_FSW         16'hF3E8
`define PCRM_RST_VINON       16'hCB40
`define PCRM_RST_VINOFF      16'hCB00
`define PCRM_RST_IGAIN       16'hCA80
`define PCRM_RST_OVF         16'h699A
`define PCRM_RST_OVR         8'h00
`define PCRM_RST_OVW         16'h6733
`define PCRM_RST_UVW         16'h58CD
`define PCRM_OP_ON_BIT       7
`define PCRM_OP_MHI          2'b10
`define PCRM_OP_MLO          2'b01
`define PCRM_NVM_TIME_NS     1000
`define PCRM_CLK_NS          50
`define PCRM_NVM_CYC         ((`PCRM_NVM_TIME_NS + `PCRM_CLK_NS - 1) / `PCRM_CLK_NS)
`endif

// ===== rtl/pcrm_pkg.sv
// Purpose: types of the command register bank
// Assumes: two output pages
// Notes:   numbers live in pcrm_consts.svh
package pcrm_pkg;
  typedef enum logic [1:0] {
    PCRM_IDLE = 2'b00,
    PCRM_SAVE = 2'b01,
    PCRM_LOAD = 2'b11
  } pcrm_nvm_st_t;
  typedef logic [15:0] pcrm_word_t;
endpackage : pcrm_pkg

// ===== rtl/pcrm_regbank.sv
// Purpose: command-code register bank behind the serial bus transaction layer
// Assumes: a transaction engine hands over decoded command, data and page
// Notes:   paged commands keep one copy per output; nvm is a flip-flop shadow
// Behaviour
// R01: unlisted codes D0..FF are maker reserved, never usable registers
// R02: unlisted codes 00..CF are unsupported
// R03: access to unsupported or reserved codes sets the command fault flag
// R04: output voltages use mode byte 0x16, unsigned mantissa times two to -10
// R05: busy shown to host while commands still being processed
// R06: defaults coded in linear-16 or 5/11 linear format per command
// R07: code 00 non-paged page select, reset 00
// R08: paged nvm-backed operating mode byte, default 40
// R09: paged enable source configuration byte, default 1E
// R10: clear-faults send byte clears all set fault bits
// R11: codes 05/06 write or read on explicit page, page select untouched
// R12: non-paged nvm-backed protection level byte, default 00
// R13: code 15 saves operating memory to nvm, 16 reloads it
// R14: read-only feature byte returns B0
// R15: paged setpoint word, linear-16, default 6000
// R16: paged ceiling word limits any commanded output, default F000
// R17: host keeps margin-high above nominal setpoint
// R18: host keeps margin-low below nominal setpoint
// R19: paged slew-rate word, default AA00
// R20: non-paged switching frequency word, default F3E8
// R21: start threshold CB40 enables, stop threshold CB00 disables conversion
// R22: paged overvoltage limit 699A, response byte default 00
// R23: 5/11 linear: signed exponent in 15:11, signed mantissa in 10:0
// R24: paged commands hold one copy per output, chosen by page
`include "pcrm_consts.svh"
`timescale 1ns/1ns
module pcrm_regbank
  import pcrm_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // command from transaction engine
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_direct,
  input  wire logic        cmd_dir_page,
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_fault,
  // device side
  input  wire logic [1:0]  run_pin,
  input  wire logic [15:0] vin_meas,
  input  wire logic        fault_set,
  output logic [1:0]       out_enable,
  output logic [15:0]      vout_target0,
  output logic [15:0]      vout_target1,
  output logic             convert_en,
  output logic [7:0]       fault_flags
);

  localparam int NVM_CYC = `PCRM_NVM_CYC;

  // 5/11 linear to signed value scaled by 2^16 [R23]
  function automatic logic signed [47:0] lin11(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    e = w[15:11];
    m = 48'(signed'(w[10:0])) <<< 16;
    lin11 = (e < 0) ? (m >>> (-e)) : (m <<< e);
  endfunction : lin11

  function automatic logic is_paged(input logic [7:0] c);
    is_paged = (c inside {`PCRM_CMD_OPMODE, `PCRM_CMD_ENSRC, `PCRM_CMD_AMASK,
               `PCRM_CMD_VSET, `PCRM_CMD_VMAX, `PCRM_CMD_MHI, `PCRM_CMD_MLO}) ||
               (c == `PCRM_CMD_SLEW) || (c >= `PCRM_CMD_OVF && c <= `PCRM_CMD_UVW);
  endfunction : is_paged

  // per-page storage [R24]
  logic [7:0]  opmode_reg [2];
  logic [7:0]  ensrc_reg  [2];
  logic [7:0]  amask_reg  [2];
  logic [15:0] vset_reg   [2];
  logic [15:0] vmax_reg   [2];
  logic [15:0] mhi_reg    [2];
  logic [15:0] mlo_reg    [2];
  logic [15:0] slew_reg   [2];
  logic [15:0] ovf_reg    [2];
  logic [7:0]  ovr_reg    [2];
  logic [15:0] ovw_reg    [2];
  logic [15:0] uvw_reg    [2];
  // nvm shadow of paged words, packed per page
  logic [159:0] nvp_reg   [2];
  logic [159:0] live_pg   [2];
  logic [7:0]  page_reg;
  logic [7:0]  prot_reg;
  logic [15:0] fsw_reg;
  logic [15:0] vinon_reg;
  logic [15:0] vinoff_reg;
  logic [15:0] igain_reg;
  logic [71:0] nvc_reg;
  logic [7:0]  fault_reg;
  logic        conv_reg;
  logic [15:0] rdata_reg;
  logic        done_reg;
  logic [$clog2(NVM_CYC+1)-1:0] nvm_cnt_reg;
  pcrm_nvm_st_t nvm_st_reg;

  wire        acc_page  = cmd_direct ? cmd_dir_page : page_reg[0];   // [R11]
  wire        go        = cmd_valid && !cmd_busy;
  wire        known     = is_paged(cmd_code) || cmd_code == `PCRM_CMD_PAGE ||
                          cmd_code == `PCRM_CMD_FCLR || cmd_code == `PCRM_CMD_PGWR ||
                          cmd_code == `PCRM_CMD_PGRD || cmd_code == `PCRM_CMD_PROT ||
                          cmd_code == `PCRM_CMD_SAVE || cmd_code == `PCRM_CMD_RELOAD ||
                          cmd_code == `PCRM_CMD_FEAT || cmd_code == `PCRM_CMD_VFMT ||
                          cmd_code == `PCRM_CMD_VMAX || cmd_code == `PCRM_CMD_FSW ||
                          cmd_code == `PCRM_CMD_VINON || cmd_code == `PCRM_CMD_VINOFF ||
                          cmd_code == `PCRM_CMD_IGAIN;
  // reserved (>= D0) and unsupported (< D0) both refused [R01] [R02]
  wire        reserved  = !known && (cmd_code >= `PCRM_RESV_LO);
  wire        ro_code   = cmd_code == `PCRM_CMD_FEAT || cmd_code == `PCRM_CMD_VFMT;
  // protection: top bit locks all writes but protection and page
  wire        locked    = prot_reg[7] && cmd_code != `PCRM_CMD_PROT &&
                          cmd_code != `PCRM_CMD_PAGE;
  wire        bad_acc   = go && (!known || (cmd_write && ro_code));              // [R03]
  wire        wr        = go && cmd_write && known && !ro_code && !locked;
  wire        clr       = go && cmd_code == `PCRM_CMD_FCLR;                      // [R10]
  wire        save_go   = wr && cmd_code == `PCRM_CMD_SAVE;                      // [R13]
  wire        load_go   = wr && cmd_code == `PCRM_CMD_RELOAD;                    // [R13]
  wire        fault_new = bad_acc || (go && cmd_write && locked) || fault_set;
  wire        unused_r  = reserved;

  assign cmd_busy  = (nvm_st_reg != PCRM_IDLE);                                 // [R05]
  assign cmd_done  = done_reg;
  assign cmd_rdata = rdata_reg;
  assign cmd_fault = fault_reg[0];
  assign fault_flags = fault_reg;
  assign convert_en  = conv_reg;

  // read mux
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (cmd_code)
      `PCRM_CMD_PAGE:   rd_mux = {8'h00, page_reg};
      `PCRM_CMD_OPMODE: rd_mux = {8'h00, opmode_reg[acc_page]};
      `PCRM_CMD_ENSRC:  rd_mux = {8'h00, ensrc_reg[acc_page]};
      `PCRM_CMD_PROT:   rd_mux = {8'h00, prot_reg};
      `PCRM_CMD_FEAT:   rd_mux = {8'h00, `PCRM_VAL_FEAT};                       // [R14]
      `PCRM_CMD_AMASK:  rd_mux = {8'h00, amask_reg[acc_page]};
      `PCRM_CMD_VFMT:   rd_mux = {8'h00, `PCRM_VAL_VFMT};                       // [R04]
      `PCRM_CMD_VSET:   rd_mux = vset_reg[acc_page];
      `PCRM_CMD_VMAX:   rd_mux = vmax_reg[acc_page];
      `PCRM_CMD_MHI:    rd_mux = mhi_reg[acc_page];
      `PCRM_CMD_MLO:    rd_mux = mlo_reg[acc_page];
      `PCRM_CMD_SLEW:   rd_mux = slew_reg[acc_page];
      `PCRM_CMD_FSW:    rd_mux = fsw_reg;
      `PCRM_CMD_VINON:  rd_mux = vinon_reg;
      `PCRM_CMD_VINOFF: rd_mux = vinoff_reg;
      `PCRM_CMD_IGAIN:  rd_mux = igain_reg;
      `PCRM_CMD_OVF:    rd_mux = ovf_reg[acc_page];
      `PCRM_CMD_OVR:    rd_mux = {8'h00, ovr_reg[acc_page]};
      `PCRM_CMD_OVW:    rd_mux = ovw_reg[acc_page];
      `PCRM_CMD_UVW:    rd_mux = uvw_reg[acc_page];
      default:          rd_mux = 16'h0000;
    endcase
  end

  // paged registers, one copy per output [R24]
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_page
      wire sel = wr && (acc_page == p);
      assign live_pg[p] = {opmode_reg[p], ensrc_reg[p], amask_reg[p], vset_reg[p],
                           vmax_reg[p], mhi_reg[p], mlo_reg[p], slew_reg[p],
                           ovf_reg[p], ovr_reg[p], ovw_reg[p], uvw_reg[p]};
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          opmode_reg[p] <= `PCRM_RST_OPMODE;                                   // [R08]
          ensrc_reg[p]  <= `PCRM_RST_ENSRC;                                    // [R09]
          amask_reg[p]  <= `PCRM_RST_AMASK;
          vset_reg[p]   <= `PCRM_RST_VSET;                                     // [R15] [R06]
          vmax_reg[p]   <= `PCRM_RST_VMAX;                                     // [R16]
          mhi_reg[p]    <= `PCRM_RST_MHI;
          mlo_reg[p]    <= `PCRM_RST_MLO;
          slew_reg[p]   <= `PCRM_RST_SLEW;                                     // [R19]
          ovf_reg[p]    <= `PCRM_RST_OVF;                                      // [R22]
          ovr_reg[p]    <= `PCRM_RST_OVR;                                      // [R22]
          ovw_reg[p]    <= `PCRM_RST_OVW;
          uvw_reg[p]    <= `PCRM_RST_UVW;
          nvp_reg[p]    <= {`PCRM_RST_OPMODE, `PCRM_RST_ENSRC, `PCRM_RST_AMASK,
                            `PCRM_RST_VSET, `PCRM_RST_VMAX, `PCRM_RST_MHI,
                            `PCRM_RST_MLO, `PCRM_RST_SLEW, `PCRM_RST_OVF,
                            `PCRM_RST_OVR, `PCRM_RST_OVW, `PCRM_RST_UVW};
        end else if (nvm_st_reg == PCRM_LOAD && nvm_cnt_reg == 0) begin
          {opmode_reg[p], ensrc_reg[p], amask_reg[p], vset_reg[p], vmax_reg[p],
           mhi_reg[p], mlo_reg[p], slew_reg[p], ovf_reg[p], ovr_reg[p],
           ovw_reg[p], uvw_reg[p]} <= nvp_reg[p];                              // [R13]
        end else begin
          if (nvm_st_reg == PCRM_SAVE && nvm_cnt_reg == 0)
            nvp_reg[p] <= live_pg[p];                                          // [R13]
          if (sel) begin
            case (cmd_code)
              `PCRM_CMD_OPMODE: opmode_reg[p] <= cmd_wdata[7:0];
              `PCRM_CMD_ENSRC:  ensrc_reg[p]  <= cmd_wdata[7:0];
              `PCRM_CMD_AMASK:  amask_reg[p]  <= cmd_wdata[7:0];
              `PCRM_CMD_VSET:   vset_reg[p]   <= cmd_wdata;
              `PCRM_CMD_VMAX:   vmax_reg[p]   <= cmd_wdata;
              `PCRM_CMD_MHI:    mhi_reg[p]    <= cmd_wdata;                    // [R17]
              `PCRM_CMD_MLO:    mlo_reg[p]    <= cmd_wdata;                    // [R18]
              `PCRM_CMD_SLEW:   slew_reg[p]   <= cmd_wdata;
              `PCRM_CMD_OVF:    ovf_reg[p]    <= cmd_wdata;
              `PCRM_CMD_OVR:    ovr_reg[p]    <= cmd_wdata[7:0];
              `PCRM_CMD_OVW:    ovw_reg[p]    <= cmd_wdata;
              `PCRM_CMD_UVW:    uvw_reg[p]    <= cmd_wdata;
              default:          ;
            endcase
          end
        end
      end
      // selected target: margin by operating mode, clamped to ceiling [R16]
      wire [1:0]  mg   = opmode_reg[p][5:4];
      wire [15:0] want = (mg == `PCRM_OP_MHI) ? mhi_reg[p] :
                         (mg == `PCRM_OP_MLO) ? mlo_reg[p] : vset_reg[p];
      wire [15:0] tgt  = (want > vmax_reg[p]) ? vmax_reg[p] : want;
      // enable: cfg bit 3 honours bus command, bit 2 honours run pin [R09]
      wire bus_ok = !ensrc_reg[p][3] || opmode_reg[p][`PCRM_OP_ON_BIT];
      wire pin_ok = !ensrc_reg[p][2] || run_pin[p];
      wire en_w   = bus_ok && pin_ok && conv_reg;
      if (p == 0) begin : g_t0
        assign vout_target0 = tgt;
      end else begin : g_t1
        assign vout_target1 = tgt;
      end
      assign out_enable[p] = en_w;
    end
  endgenerate

  // non-paged registers and sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_reg    <= `PCRM_RST_PAGE;                                           // [R07]
      prot_reg    <= `PCRM_RST_PROT;                                           // [R12]
      fsw_reg     <= `PCRM_RST_FSW;                                            // [R20]
      vinon_reg   <= `PCRM_RST_VINON;                                          // [R21]
      vinoff_reg  <= `PCRM_RST_VINOFF;                                         // [R21]
      igain_reg   <= `PCRM_RST_IGAIN;
      nvc_reg     <= {`PCRM_RST_PROT, `PCRM_RST_FSW, `PCRM_RST_VINON,
                      `PCRM_RST_VINOFF, `PCRM_RST_IGAIN};
      fault_reg   <= 8'h00;
      conv_reg    <= 1'b0;
      rdata_reg   <= 16'h0000;
      done_reg    <= 1'b0;
      nvm_st_reg  <= PCRM_IDLE;
      nvm_cnt_reg <= '0;
    end else begin
      done_reg <= go;
      if (go && !cmd_write)
        rdata_reg <= rd_mux;
      // new fault wins over clear [R10]
      if (fault_new)
        fault_reg <= (clr ? 8'h00 : fault_reg) | {7'h00, fault_new};
      else if (clr)
        fault_reg <= 8'h00;
      // hysteresis on input thresholds, values in 5/11 linear [R21]
      if (lin11(vin_meas) >= lin11(vinon_reg))
        conv_reg <= 1'b1;
      else if (lin11(vin_meas) < lin11(vinoff_reg))
        conv_reg <= 1'b0;
      case (nvm_st_reg)
        PCRM_IDLE: begin
          if (save_go || load_go) begin
            nvm_st_reg  <= save_go ? PCRM_SAVE : PCRM_LOAD;
            nvm_cnt_reg <= ($clog2(NVM_CYC+1))'(NVM_CYC - 1);
          end
        end
        PCRM_SAVE, PCRM_LOAD: begin
          if (nvm_cnt_reg == 0) begin
            nvm_st_reg <= PCRM_IDLE;
            if (nvm_st_reg == PCRM_SAVE)
              nvc_reg <= {prot_reg, fsw_reg, vinon_reg, vinoff_reg, igain_reg};
            else
              {prot_reg, fsw_reg, vinon_reg, vinoff_reg, igain_reg} <= nvc_reg;
          end else begin
            nvm_cnt_reg <= nvm_cnt_reg - 1'b1;
          end
        end
        default: nvm_st_reg <= PCRM_IDLE;
      endcase
      // direct-page access leaves page select alone [R11]
      if (wr && !cmd_direct) begin
        case (cmd_code)
          `PCRM_CMD_PAGE:   page_reg   <= cmd_wdata[7:0];
          `PCRM_CMD_PROT:   prot_reg   <= cmd_wdata[7:0];
          `PCRM_CMD_FSW:    fsw_reg    <= cmd_wdata;
          `PCRM_CMD_VINON:  vinon_reg  <= cmd_wdata;
          `PCRM_CMD_VINOFF: vinoff_reg <= cmd_wdata;
          `PCRM_CMD_IGAIN:  igain_reg  <= cmd_wdata;
          default:          ;
        endcase
      end else if (wr) begin
        case (cmd_code)
          `PCRM_CMD_PROT:   prot_reg   <= cmd_wdata[7:0];
          `PCRM_CMD_FSW:    fsw_reg    <= cmd_wdata;
          `PCRM_CMD_VINON:  vinon_reg  <= cmd_wdata;
          `PCRM_CMD_VINOFF: vinoff_reg <= cmd_wdata;
          `PCRM_CMD_IGAIN:  igain_reg  <= cmd_wdata;
          default:          ;
        endcase
      end
    end
  end

endmodule : pcrm_regbank

// ===== verif/pcrm_regbank_assertions.sv
// Purpose: concurrent checks on the command register bank ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every pcrm_regbank instance
`timescale 1ns/1ns
module pcrm_regbank_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // command side
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_busy,
  input wire logic        cmd_done,
  input wire logic        cmd_fault,
  // device side
  input wire logic        fault_set,
  input wire logic [7:0]  fault_flags,
  input wire logic [15:0] vout_target0,
  input wire logic [15:0] vout_target1
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire taken_w  = cmd_valid && !cmd_busy;
  wire listed_w = cmd_code inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h10, 8'h15,
    8'h16, 8'h19, 8'h1B, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h33, 8'h35, 8'h36,
    8'h38, 8'h40, 8'h41, 8'h42, 8'h43};

  take_done_a: assert property (taken_w |=> cmd_done)
    else $error("no done after taken request");
  busy_refuse_a: assert property (cmd_busy |=> !cmd_done)
    else $error("request taken while busy");
  fault_mirror_a: assert property (cmd_fault == fault_flags[0])
    else $error("fault output differs from flag bit");
  resv_fault_a: assert property (taken_w && cmd_code >= 8'hD0 |=> cmd_fault)
    else $error("reserved code without fault");
  unsup_fault_a: assert property (taken_w && !listed_w && cmd_code < 8'hD0 |=> cmd_fault)
    else $error("unsupported code without fault");
  fault_clear_a: assert property (
    taken_w && cmd_write && cmd_code == 8'h03 && !fault_set |=> !cmd_fault)
    else $error("clear faults left fault set");
  fault_event_a: assert property (fault_set |=> cmd_fault)
    else $error("fault event not recorded");
  save_busy_a: assert property (
    taken_w && cmd_write && cmd_code == 8'h15 |=> cmd_busy [*8] ##[1:20] !cmd_busy)
    else $error("save busy window wrong");
  reset_target_a: assert property (
    $fell(rst) |-> vout_target0 == 16'h6000 && vout_target1 == 16'h6000)
    else $error("setpoint not at default after reset");
endmodule : pcrm_regbank_chk

bind pcrm_regbank pcrm_regbank_chk chk_u (.ref_clk(ref_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_fault(cmd_fault), .fault_set(fault_set),
  .fault_flags(fault_flags), .vout_target0(vout_target0), .vout_target1(vout_target1));

// ===== verif/pcrm_host_model.sv
// Purpose: host that issues one command at a time to the register bank
// Assumes: request held until taken on an edge with busy low
// Notes:   released code, data and page lines show inverted values so stale data never matches
`timescale 1ns/1ns
module pcrm_host_model (
  // clock
  input  wire logic        ref_clk,
  // answers
  input  wire logic        cmd_busy,
  input  wire logic        cmd_done,
  input  wire logic [15:0] cmd_rdata,
  // request
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  output logic             cmd_direct,
  output logic             cmd_dir_page
);
  initial begin
    cmd_valid = 1'b0; cmd_write = 1'b0; cmd_code = 8'hFF;
    cmd_wdata = 16'hFFFF; cmd_direct = 1'b0; cmd_dir_page = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic dr, input logic dp, output logic ok, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge ref_clk); #1;
    cmd_valid = 1'b1; cmd_write = w; cmd_code = c; cmd_wdata = d;
    cmd_direct = dr; cmd_dir_page = dp;
    // hold the request while the device reports busy
    while (cmd_busy !== 1'b0 && n < 100) begin
      @(posedge ref_clk); #1;
      n++;
    end
    @(posedge ref_clk); #1;
    ok = cmd_done;
    q = cmd_rdata;
    cmd_valid = 1'b0; cmd_code = ~c; cmd_wdata = ~d; cmd_dir_page = ~dp;
  endtask : xfer
endmodule : pcrm_host_model

// ===== verif/tb.sv
// Purpose: self-checking bench for the command register bank
// Assumes: host model issues one command at a time, page 0 unless stated
// Notes:   expected values come from the register table and mode encodings
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  localparam logic [23:0] def_tab [20] = '{24'h000000, 24'h010040, 24'h02001E, 24'h100000,
    24'h1900B0, 24'h1B0000, 24'h200016, 24'h216000, 24'h24F000, 24'h2564CD, 24'h265B33,
    24'h27AA00, 24'h33F3E8, 24'h35CB40, 24'h36CB00, 24'h38CA80, 24'h40699A, 24'h410000,
    24'h426733, 24'h4358CD};
  localparam logic [7:0] bad_tab [6] = '{8'h04, 8'h07, 8'h22, 8'hCF, 8'hD0, 8'hFF};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid, cmd_write, cmd_direct, cmd_dir_page, cmd_busy, cmd_done, cmd_fault;
  logic [7:0]  cmd_code, fault_flags;
  logic [15:0] cmd_wdata, cmd_rdata, vout_target0, vout_target1, rd_v;
  logic [1:0]  run_pin = 2'b00;
  logic [1:0]  out_enable;
  logic [15:0] vin_meas = 16'h0000;
  logic        fault_set = 1'b0;
  logic        convert_en, ok_v;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #25 ref_clk = ~ref_clk;

  pcrm_regbank dut_u (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_direct(cmd_direct), .cmd_dir_page(cmd_dir_page), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .cmd_fault(cmd_fault), .run_pin(run_pin),
    .vin_meas(vin_meas), .fault_set(fault_set), .out_enable(out_enable),
    .vout_target0(vout_target0), .vout_target1(vout_target1), .convert_en(convert_en),
    .fault_flags(fault_flags));

  pcrm_host_model host_u (.ref_clk(ref_clk), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
    .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_direct(cmd_direct),
    .cmd_dir_page(cmd_dir_page));

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(1'b1, c, d, 1'b0, 1'b0, ok_v, rd_v);
    `CHK(ok_v, 1'b1)
  endtask : wr

  task automatic rd(input logic [7:0] c);
    host_u.xfer(1'b0, c, 16'h0000, 1'b0, 1'b0, ok_v, rd_v);
  endtask : rd

  task automatic t_defaults;
    for (int i = 0; i < 20; i++) begin
      rd(def_tab[i][23:16]);
      `CHK(rd_v, def_tab[i][15:0])
    end
    `CHK(cmd_fault, 1'b0)
    $display("defaults done");
  endtask : t_defaults

  task automatic t_refuse;
    wr(8'h19, 16'h00FF);
    `CHK(cmd_fault, 1'b1)
    wr(8'h03, 16'h0000);
    `CHK(cmd_fault, 1'b0)
    rd(8'h19);
    `CHK(rd_v, 16'h00B0)
    wr(8'h20, 16'h0000);
    `CHK(cmd_fault, 1'b1)
    wr(8'h03, 16'h0000);
    rd(8'h20);
    `CHK(rd_v, 16'h0016)
    `CHK(cmd_fault, 1'b0)
    wr(8'h10, 16'h0080);
    wr(8'h21, 16'h1234);
    `CHK(cmd_fault, 1'b1)
    wr(8'h10, 16'h0000);
    wr(8'h03, 16'h0000);
    rd(8'h21);
    `CHK(rd_v, 16'h6000)
    $display("refusals done");
  endtask : t_refuse

  task automatic t_codes;
    foreach (bad_tab[i]) begin
      host_u.xfer(i[0], bad_tab[i], 16'h5A5A, 1'b0, 1'b0, ok_v, rd_v);
      `CHK(cmd_fault, 1'b1)
      wr(8'h03, 16'h0000);
      `CHK(fault_flags, 8'h00)
    end
    fault_set = 1'b1;
    @(posedge ref_clk); #1;
    fault_set = 1'b0;
    `CHK(cmd_fault, 1'b1)
    wr(8'h03, 16'h0000);
    `CHK(cmd_fault, 1'b0)
    $display("codes done");
  endtask : t_codes

  task automatic t_paging;
    vin_meas = 16'hCB80;
    wr(8'h21, 16'h5C00);
    `CHK(vout_target0, 16'h5C00)
    wr(8'h00, 16'h0001);
    rd(8'h21);
    `CHK(rd_v, 16'h6000)
    host_u.xfer(1'b1, 8'h21, 16'h5E00, 1'b1, 1'b0, ok_v, rd_v);
    rd(8'h00);
    `CHK(rd_v, 16'h0001)
    `CHK(vout_target0, 16'h5E00)
    host_u.xfer(1'b0, 8'h21, 16'h0000, 1'b1, 1'b0, ok_v, rd_v);
    `CHK(rd_v, 16'h5E00)
    wr(8'h00, 16'h0000);
    wr(8'h21, 16'h6000); // margins stay around nominal
    run_pin = 2'b01;
    wr(8'h01, 16'h00A0);
    `CHK(vout_target0, 16'h64CD)
    `CHK(out_enable[0], 1'b1)
    wr(8'h24, 16'h6200);
    `CHK(vout_target0, 16'h6200)
    wr(8'h01, 16'h0090);
    `CHK(vout_target0, 16'h5B33)
    run_pin = 2'b00;
    #1;
    `CHK(out_enable[0], 1'b0)
    $display("paging done");
  endtask : t_paging

  task automatic t_nvm;
    wr(8'h21, 16'h6100);
    wr(8'h15, 16'h0000);
    `CHK(cmd_busy, 1'b1)
    wr(8'h21, 16'h5F00);
    wr(8'h16, 16'h0000);
    rd(8'h21);
    `CHK(rd_v, 16'h6100)
    $display("nvm done");
  endtask : t_nvm

  task automatic t_input;
    vin_meas = 16'hCB80;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(convert_en, 1'b1)
    vin_meas = 16'hCB20;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(convert_en, 1'b1)
    vin_meas = 16'hCA80;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(convert_en, 1'b0)
    $display("input done");
  endtask : t_input

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_defaults();
    t_refuse();
    t_codes();
    t_input();
    t_paging();
    t_nvm();
    end_of_test();
  end
endmodule : tb
